// file: count_clock_select.sv
// Counter clock enable generator and source selector
`include "periodic_timer_params.svh"
`default_nettype none
module count_clock_select (
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_hs_tick,
  input  wire logic       i_sub_tick,
  input  wire logic [2:0] i_clock_select,
  output logic            o_count_tick
);

  logic [1:0] sys_div;
  logic [5:0] hs_div;
  logic       next_tick;

  // ==========================================================
  // Dividers
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sys_div <= 2'h0;
    end else begin
      sys_div <= sys_div + 2'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hs_div <= 6'h00;
    end else if (i_hs_tick) begin
      hs_div <= hs_div + 6'h01;
    end
  end

  // ==========================================================
  // Internal sources only, reserved codes give no tick
  always_comb begin
    unique case (periodic_timer_pkg::csel_t'(i_clock_select))
      periodic_timer_pkg::CSEL_SYS4:
        next_tick = (sys_div == `PT_SYS_DIV_LAST);
      periodic_timer_pkg::CSEL_SYS:  next_tick = 1'b1;
      periodic_timer_pkg::CSEL_HS16:
        next_tick = i_hs_tick && (hs_div[3:0] == `PT_HS16_LAST);
      periodic_timer_pkg::CSEL_HS64:
        next_tick = i_hs_tick && (hs_div == `PT_HS64_LAST);
      periodic_timer_pkg::CSEL_SUB0: next_tick = i_sub_tick;
      periodic_timer_pkg::CSEL_SUB1: next_tick = i_sub_tick;
      periodic_timer_pkg::CSEL_RES0: next_tick = 1'b0;
      periodic_timer_pkg::CSEL_RES1: next_tick = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_count_tick <= 1'b0;
    end else begin
      o_count_tick <= next_tick;
    end
  end

endmodule
`default_nettype wire

// file: periodic_timer.sv
// Ten-bit periodic timer with Avalon-MM register slave
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`include "periodic_timer_params.svh"
`default_nettype none
module periodic_timer (
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_hs_tick,
  input  wire logic        i_sub_tick,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_timer_output_pin,
  output logic             o_match_a_flag,
  output logic             o_match_p_flag
);

  // ==========================================================
  // Declarations
  logic        ack;
  logic        wr_go;
  logic        wr_lane;
  logic        pause_bit;
  logic [2:0]  clock_select;
  logic        run_bit;
  logic        run_q;
  logic [7:0]  periodic_timer_ctrl1;
  logic [9:0]  compare_a_value;
  logic [9:0]  compare_p_value;
  logic [9:0]  count;
  logic [10:0] cnt_inc;
  logic        count_tick;
  logic        start;
  logic        en;
  logic        hit_a;
  logic        hit_p;
  logic        set_a;
  logic        set_p;
  logic        hw_clr;
  logic        sp_stop;
  logic        pin_q;
  logic        level;
  logic        next_pin;
  logic        oc;
  logic        inv;
  logic        clr_sel;
  logic [1:0]  pin_fn;
  periodic_timer_pkg::mode_t mode;

  assign mode    = periodic_timer_pkg::mode_t'(periodic_timer_ctrl1[7:6]);
  assign pin_fn  = periodic_timer_ctrl1[`PT_C1_PF_HI:`PT_C1_PF_LO];
  assign oc      = periodic_timer_ctrl1[`PT_C1_OC];
  assign inv     = periodic_timer_ctrl1[`PT_C1_INV];
  assign clr_sel = periodic_timer_ctrl1[`PT_C1_CLRSEL];

  // ==========================================================
  // Read decode
  function automatic logic [7:0] read_reg(input logic [3:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      `PT_IDX_CTRL0:   v = {pause_bit, clock_select, run_bit, 3'h0};
      `PT_IDX_CTRL1:   v = periodic_timer_ctrl1;
      `PT_IDX_CNT_LO:  v = count[7:0];
      `PT_IDX_CNT_HI:  v = {6'h00, count[9:8]};
      `PT_IDX_CMPA_LO: v = compare_a_value[7:0];
      `PT_IDX_CMPA_HI: v = {6'h00, compare_a_value[9:8]};
      `PT_IDX_CMPP_LO: v = compare_p_value[7:0];
      `PT_IDX_CMPP_HI: v = {6'h00, compare_p_value[9:8]};
      `PT_IDX_FLAGS:   v = {6'h00, o_match_p_flag, o_match_a_flag};
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Avalon slave: one wait state on every access
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;
  assign wr_go   = i_avs_write && ack;
  assign wr_lane = wr_go && i_avs_byteenable[0];

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_avs_read || i_avs_write) && !ack;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack) begin
      o_avs_readdata <= {24'h00_0000, read_reg(i_avs_address)};
    end
  end

  // ==========================================================
  // Control register zero
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pause_bit    <= 1'b0;
      clock_select <= 3'h0;
      run_bit      <= 1'b0;
    end else if (wr_lane && i_avs_address == `PT_IDX_CTRL0) begin
      pause_bit    <= i_avs_writedata[`PT_C0_PAUSE];
      clock_select <= i_avs_writedata[`PT_C0_CSEL_HI:`PT_C0_CSEL_LO];
      run_bit      <= i_avs_writedata[`PT_C0_RUN];
    end else if (sp_stop) begin
      run_bit      <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_bit;
    end
  end

  assign start = run_bit && !run_q;

  // ==========================================================
  // Control register one and compare pairs
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      periodic_timer_ctrl1 <= `PT_CTRL1_RST;
    end else if (wr_lane && i_avs_address == `PT_IDX_CTRL1) begin
      periodic_timer_ctrl1 <= i_avs_writedata[7:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      compare_a_value <= `PT_CMP_RST;
    end else if (wr_lane && i_avs_address == `PT_IDX_CMPA_LO) begin
      compare_a_value[7:0] <= i_avs_writedata[7:0];
    end else if (wr_lane && i_avs_address == `PT_IDX_CMPA_HI) begin
      compare_a_value[9:8] <= i_avs_writedata[1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      compare_p_value <= `PT_CMP_RST;
    end else if (wr_lane && i_avs_address == `PT_IDX_CMPP_LO) begin
      compare_p_value[7:0] <= i_avs_writedata[7:0];
    end else if (wr_lane && i_avs_address == `PT_IDX_CMPP_HI) begin
      compare_p_value[9:8] <= i_avs_writedata[1:0];
    end
  end

  // ==========================================================
  // Counter clock
  count_clock_select u_clk_sel (
    .i_sys_clk      (i_sys_clk),
    .i_arst_n       (i_arst_n),
    .i_hs_tick      (i_hs_tick),
    .i_sub_tick     (i_sub_tick),
    .i_clock_select (clock_select),
    .o_count_tick   (count_tick)
  );

  // ==========================================================
  // Comparators
  assign en      = count_tick && run_bit && !pause_bit && !start;
  assign cnt_inc = {1'b0, count} + 11'h001;
  assign hit_a   = en && (compare_a_value != `PT_CMP_RST)
                   && (cnt_inc[9:0] == compare_a_value);
  assign hit_p   = en && ((compare_p_value == `PT_CMP_RST) ? cnt_inc[10]
                   : (cnt_inc[9:0] == compare_p_value));

  always_comb begin
    set_a   = hit_a;
    set_p   = hit_p;
    hw_clr  = 1'b0;
    sp_stop = 1'b0;
    unique case (mode)
      periodic_timer_pkg::MODE_CMP,
      periodic_timer_pkg::MODE_TC: begin
        if (clr_sel) begin
          hw_clr = hit_a;
          set_p  = 1'b0;
        end else begin
          hw_clr = hit_p;
        end
      end
      periodic_timer_pkg::MODE_PWM: begin
        if (pin_fn == 2'b11) begin
          sp_stop = hit_a;
          set_p   = 1'b0;
        end else begin
          hw_clr = hit_p;
        end
      end
      periodic_timer_pkg::MODE_UNDEF: begin
        set_a = 1'b0;
        set_p = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Counter
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count <= 10'h000;
    end else if (start) begin
      count <= 10'h000;
    end else if (hw_clr) begin
      count <= 10'h000;
    end else if (en) begin
      count <= cnt_inc[9:0];
    end
  end

  // ==========================================================
  // Match flags, write one to clear, set wins
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_match_a_flag <= 1'b0;
      o_match_p_flag <= 1'b0;
    end else begin
      if (set_a) begin
        o_match_a_flag <= 1'b1;
      end else if (wr_lane && i_avs_address == `PT_IDX_FLAGS
                   && i_avs_writedata[`PT_FL_A]) begin
        o_match_a_flag <= 1'b0;
      end
      if (set_p) begin
        o_match_p_flag <= 1'b1;
      end else if (wr_lane && i_avs_address == `PT_IDX_FLAGS
                   && i_avs_writedata[`PT_FL_P]) begin
        o_match_p_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Compare-match pin state
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_q <= 1'b0;
    end else if (start) begin
      pin_q <= oc;
    end else if (set_a && mode == periodic_timer_pkg::MODE_CMP) begin
      unique case (pin_fn)
        2'b00: pin_q <= pin_q;
        2'b01: pin_q <= 1'b0;
        2'b10: pin_q <= 1'b1;
        2'b11: pin_q <= !pin_q;
      endcase
    end
  end

  // ==========================================================
  // Pin level per mode
  always_comb begin
    level = pin_q;
    if (mode == periodic_timer_pkg::MODE_PWM) begin
      unique case (pin_fn)
        2'b00: level = !oc;
        2'b01: level = oc;
        2'b10: level = (count < compare_a_value) ? oc : !oc;
        2'b11: level = run_bit ? oc : !oc;
      endcase
    end
    if (mode == periodic_timer_pkg::MODE_TC) begin
      next_pin = 1'b0;
    end else begin
      next_pin = level ^ inv;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_timer_output_pin <= 1'b0;
    end else begin
      o_timer_output_pin <= next_pin;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_start;
    start;
  endsequence

  sequence s_count_zero;
    count == 10'h000;
  endsequence

  a_start_clears: assert property (s_start |=> s_count_zero)
    else $error("Counter not zero after run rise");

  a_pause_holds: assert property (
    (pause_bit && !start) |=> $stable(count))
    else $error("Counter moved while paused");

  a_clrsel_no_p: assert property (
    (clr_sel && mode == periodic_timer_pkg::MODE_CMP && hit_p && !hit_a
     && !(wr_lane && i_avs_address == `PT_IDX_FLAGS))
    |=> $stable(o_match_p_flag))
    else $error("P flag moved with clear select high");

  a_zero_a_noflag: assert property (
    (compare_a_value == 10'h000) |-> !set_a)
    else $error("A flag source with A value zero");

  a_clear_flags: assert property (
    hw_clr |=> (s_count_zero and (o_match_a_flag || o_match_p_flag)))
    else $error("Clear without flag or zero count");

  a_single_stop: assert property (
    (sp_stop && !wr_go) |=> (!run_bit ##1 !run_bit))
    else $error("Single pulse did not stop");

  a_cmp_start_pin: assert property (
    (start && mode == periodic_timer_pkg::MODE_CMP)
    |=> ##1 (o_timer_output_pin == (oc ^ inv)))
    else $error("Pin not at initial level after run rise");

  a_ctrl0_low_zero: assert property (
    (i_avs_read && !ack && i_avs_address == `PT_IDX_CTRL0)
    |=> (o_avs_readdata[2:0] == 3'h0))
    else $error("Control zero low bits not zero");

  a_tc_pin_low: assert property (
    (mode == periodic_timer_pkg::MODE_TC) |=> !o_timer_output_pin)
    else $error("Pin driven in timer mode");

  a_one_wait: assert property (
    o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("Wait longer than one cycle");

endmodule
`default_nettype wire

// file: periodic_timer_params.svh
// Constants of the periodic timer: offsets, fields, resets, divider counts
// What this block does
// - Ten-bit up-counter compared by comparators A and P over all bits.
// - Counter clears only by run-bit rise, overflow or selected match clear.
// - Counter clear by overflow or match raises a timer request flag.
// - Pause bit seven holds the count; counting resumes when it drops.
// - Clock select picks sys/4, sys, hs/16, hs/64 or sub; 110, 111 reserved.
// - Run bit three: rise zeroes counter, fall keeps the value.
// - Run rise returns output pin to its initial level in output modes.
// - Compare mode: A match keeps, drives low, drives high or toggles pin.
// - PWM modes: force inactive, force active, PWM, single pulse.
// - Output control sets initial level, PWM polarity, pulse start level.
// - Output invert bit two inverts the pin, except in timer mode.
// - Clear select in compare and timer modes: one clears on A, zero on P or overflow.
// - Count readable as a pair; A and P held in pairs of ten bits.
// - Bits two to zero of control zero read as zero.
// - No external clock pin; counter clock only from internal sources.
// - In compare and timer modes, clear select one raises only the A flag.
// - A value zero: count wraps at 3ff without an A flag.
// - PWM period is P clocks, zero meaning 1024; A sets the duty.
// - PWM raises a flag on every A match and, except in single pulse, every P match.
`ifndef PERIODIC_TIMER_PARAMS_SVH
`define PERIODIC_TIMER_PARAMS_SVH

// ==========================================================
// Register word indices
`define PT_IDX_CTRL0    4'h0
`define PT_IDX_CTRL1    4'h1
`define PT_IDX_CNT_LO   4'h2
`define PT_IDX_CNT_HI   4'h3
`define PT_IDX_CMPA_LO  4'h4
`define PT_IDX_CMPA_HI  4'h5
`define PT_IDX_CMPP_LO  4'h6
`define PT_IDX_CMPP_HI  4'h7
`define PT_IDX_FLAGS    4'h8

// ==========================================================
// Field positions
`define PT_C0_PAUSE     7
`define PT_C0_CSEL_HI   6
`define PT_C0_CSEL_LO   4
`define PT_C0_RUN       3
`define PT_C1_MODE_HI   7
`define PT_C1_MODE_LO   6
`define PT_C1_PF_HI     5
`define PT_C1_PF_LO     4
`define PT_C1_OC        3
`define PT_C1_INV       2
`define PT_C1_CLRSEL    0
`define PT_FL_A         0
`define PT_FL_P         1

// ==========================================================
// Reset values
`define PT_CTRL0_RST    8'h00
`define PT_CTRL1_RST    8'h00
`define PT_CMP_RST      10'h000
`define PT_CNT_MAX      10'h3ff

// ==========================================================
// Divider counts
`define PT_SYS_DIV_LAST 2'h3
`define PT_HS16_LAST    4'hf
`define PT_HS64_LAST    6'h3f

`endif

// file: periodic_timer_pkg.sv
// Types shared by the periodic timer files
`default_nettype none
package periodic_timer_pkg;

  // ==========================================================
  // Operating modes
  typedef enum logic [1:0] {
    MODE_CMP   = 2'b00,
    MODE_UNDEF = 2'b01,
    MODE_PWM   = 2'b10,
    MODE_TC    = 2'b11
  } mode_t;

  // ==========================================================
  // Counter clock sources
  typedef enum logic [2:0] {
    CSEL_SYS4  = 3'b000,
    CSEL_SYS   = 3'b001,
    CSEL_HS16  = 3'b010,
    CSEL_HS64  = 3'b011,
    CSEL_SUB0  = 3'b100,
    CSEL_SUB1  = 3'b101,
    CSEL_RES0  = 3'b110,
    CSEL_RES1  = 3'b111
  } csel_t;

endpackage
`default_nettype wire

// file: tb.sv
// Self-checking testbench of the ten-bit periodic timer
`include "periodic_timer_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals, counters and compare macro
  logic        sys_clk;
  logic        arst_n;
  logic        hs_tick;
  logic        sub_tick;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pin;
  logic        flag_a;
  logic        flag_p;
  int          errors;
  int          n_compared;
  int          cycles;
  int          tick_cnt;
  localparam int LIMIT = 30000;

  `define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    errors++; $display("wrong value at %0t: got %h expected %h", \
    $time, got, exp); end end

  periodic_timer dut (
    .i_sys_clk         (sys_clk),
    .i_arst_n          (arst_n),
    .i_hs_tick         (hs_tick),
    .i_sub_tick        (sub_tick),
    .i_avs_address     (avs_address),
    .i_avs_read        (avs_read),
    .i_avs_write       (avs_write),
    .i_avs_writedata   (avs_writedata),
    .i_avs_byteenable  (avs_byteenable),
    .o_avs_readdata    (avs_readdata),
    .o_avs_waitrequest (avs_waitrequest),
    .o_timer_output_pin(pin),
    .o_match_a_flag    (flag_a),
    .o_match_p_flag    (flag_p)
  );

  // ==========================================================
  // Clock, tick sources and timeout
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    tick_cnt <= tick_cnt + 1;
    hs_tick  <= (tick_cnt % 2) == 0;
    sub_tick <= (tick_cnt % 3) == 0;
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus cycles
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, input logic [3:0] be,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 50) errors++;
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, 4'h1, q);
  endtask

  task automatic rd_count(output logic [9:0] c);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(`PT_IDX_CNT_LO, lo);
    rd(`PT_IDX_CNT_HI, hi);
    c = {hi[1:0], lo};
  endtask

  task automatic setup(input logic [9:0] a, input logic [9:0] p,
                       input logic [7:0] c1);
    wr(`PT_IDX_CTRL0, 8'h10);
    wr(`PT_IDX_CMPA_LO, a[7:0]);
    wr(`PT_IDX_CMPA_HI, {6'h0, a[9:8]});
    wr(`PT_IDX_CMPP_LO, p[7:0]);
    wr(`PT_IDX_CMPP_HI, {6'h0, p[9:8]});
    wr(`PT_IDX_CTRL1, c1);
    wr(`PT_IDX_FLAGS, 8'h03);
    wr(`PT_IDX_CTRL0, 8'h18);
  endtask

  task automatic wait_a();
    int n;
    n = 0;
    while (flag_a !== 1'b1 && n < 1200) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic ones(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (pin === 1'b1) k++;
    end
  endtask

  // ==========================================================
  // Register rows: address, byte enable, written, read back
  typedef struct {
    logic [3:0] a;
    logic [3:0] be;
    logic [7:0] d;
    logic [7:0] e;
  } reg_row_t;
  reg_row_t rows[12] = '{
    '{4'h1, 4'h1, 8'hfd, 8'hfd}, '{4'h1, 4'h1, 8'h00, 8'h00},
    '{4'h0, 4'h1, 8'h07, 8'h00}, '{4'h4, 4'h1, 8'ha5, 8'ha5},
    '{4'h5, 4'h1, 8'hff, 8'h03}, '{4'h6, 4'h1, 8'h5a, 8'h5a},
    '{4'h7, 4'h1, 8'hfe, 8'h02}, '{4'h2, 4'h1, 8'hff, 8'h00},
    '{4'h3, 4'h1, 8'hff, 8'h00}, '{4'h4, 4'h0, 8'h11, 8'ha5},
    '{4'h9, 4'h1, 8'hff, 8'h00}, '{4'hf, 4'h1, 8'hff, 8'h00}};
  // Compare mode rows: ctrl1, level after run rise, level after A match
  logic [7:0] cm_c1[5] = '{8'h18, 8'h20, 8'h30, 8'h08, 8'h24};
  logic       cm_i[5]  = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic       cm_f[5]  = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  int         div[6]   = '{4, 1, 32, 128, 3, 3};

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] q;
    logic [9:0] c1;
    logic [9:0] c2;
    int         k;
    errors = 0; n_compared = 0;
    arst_n = 1'b0;
    avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; avs_byteenable = 4'h0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i <= 8; i++) begin
      rd(i[3:0], q);
      `CHK(q, 8'h00)
    end
    `CHK({pin, flag_a, flag_p}, 3'b000)
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].be, q);
      rd(rows[i].a, q);
      `CHK(q, rows[i].e)
    end
    // Compare mode pin actions, P clears and flags
    foreach (cm_c1[i]) begin
      setup(10'd200, 10'd250, cm_c1[i]);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK(pin, cm_i[i])
      wait_a();
      `CHK(pin, cm_f[i])
      repeat (60) @(posedge sys_clk);
      `CHK(flag_p, 1'b1)
    end
    // Clear on A only
    setup(10'd40, 10'd10, 8'h01);
    repeat (200) @(posedge sys_clk);
    `CHK({flag_a, flag_p}, 2'b10)
    // A of zero never matches; P of zero overflows at the top
    setup(10'd0, 10'd5, 8'h01);
    repeat (1100) @(posedge sys_clk);
    `CHK({flag_a, flag_p}, 2'b00)
    setup(10'd0, 10'd0, 8'h00);
    repeat (1100) @(posedge sys_clk);
    `CHK({flag_a, flag_p}, 2'b01)
    // Pause, run fall and run rise
    setup(10'd0, 10'd0, 8'h00);
    repeat (50) @(posedge sys_clk);
    wr(`PT_IDX_CTRL0, 8'h98);
    rd_count(c1);
    repeat (10) @(posedge sys_clk);
    rd_count(c2);
    `CHK(c2, c1)
    wr(`PT_IDX_CTRL0, 8'h18);
    repeat (10) @(posedge sys_clk);
    rd_count(c2);
    `CHK(c2 > c1, 1'b1)
    wr(`PT_IDX_CTRL0, 8'h10);
    rd_count(c1);
    repeat (10) @(posedge sys_clk);
    rd_count(c2);
    `CHK(c2, c1)
    `CHK(c2 != 10'h000, 1'b1)
    wr(`PT_IDX_CTRL0, 8'h18);
    rd_count(c2);
    `CHK(c2 < 10'd8, 1'b1)
    // Counter clock sources
    foreach (div[i]) begin
      wr(`PT_IDX_CTRL0, {1'b0, i[2:0], 4'h0});
      wr(`PT_IDX_CTRL0, {1'b0, i[2:0], 4'h8});
      repeat (512) @(posedge sys_clk);
      wr(`PT_IDX_CTRL0, {1'b1, i[2:0], 4'h8});
      rd_count(c1);
      k = 512 / div[i];
      `CHK(c1 + 10'd2 >= k[9:0] && c1 <= k[9:0] + 10'd6, 1'b1)
    end
    // PWM duty, polarity, forced levels and both flags
    setup(10'd3, 10'd8, 8'ha8);
    repeat (20) @(posedge sys_clk);
    ones(16, k);
    `CHK(k[7:0], 8'd6)
    `CHK({flag_a, flag_p}, 2'b11)
    setup(10'd3, 10'd8, 8'hac);
    repeat (20) @(posedge sys_clk);
    ones(16, k);
    `CHK(k[7:0], 8'd10)
    setup(10'd3, 10'd8, 8'h88);
    ones(16, k);
    `CHK(k[7:0], 8'd0)
    setup(10'd3, 10'd8, 8'h98);
    ones(16, k);
    `CHK(k[7:0], 8'd16)
    // Single pulse
    setup(10'd20, 10'd5, 8'hb8);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(pin, 1'b1)
    wait_a();
    `CHK({pin, flag_p}, 2'b00)
    rd(`PT_IDX_CTRL0, q);
    `CHK(q, 8'h10)
    rd_count(c1);
    rd_count(c2);
    `CHK(c2, c1)
    // Timer mode keeps flags, pin unused
    setup(10'd20, 10'd0, 8'he8);
    wait_a();
    `CHK({pin, flag_a}, 2'b01)
    // Reset in mid-run
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    `CHK({pin, flag_a, flag_p}, 3'b000)
    rd(`PT_IDX_CTRL0, q);
    `CHK(q, 8'h00)
    summarize();
  end
endmodule
`default_nettype wire
